//--- sdc_pkg.sv
// Constants and carrier types for the segment display scan controller.
// Assumes a 100 MHz mclk and an 8-bit processor data space.
package sdc_pkg;
  // Data-space map
  localparam logic [7:0] CTRL_ADDR  = 8'hDC;  // display_mode_control
  localparam logic [7:0] RAM_LAST   = 8'h3F;  // Last display RAM byte
  localparam logic [7:0] CTRL_RESET = 8'h00;  // Control reset value
  // Display RAM geometry
  localparam int         RAM_BYTES  = 64;     // Bytes per page
  localparam int         SEG_MAX    = 56;     // Segment lines in 1/8
  localparam int         SEG_WIDE   = 48;     // Segment lines in 1/11, 1/16
  localparam int         COM_MAX    = 16;     // Common plate lines
  localparam int         BYTE_SKIP  = 8;      // Bytes 00..07 skipped when wide
  // Clock source codes
  localparam logic [2:0] SRC_OFF    = 3'h0;   // Clock disabled
  localparam logic [2:0] SRC_AUX    = 3'h1;   // Auxiliary slow oscillator
  localparam logic [2:0] SRC_RSV_A  = 3'h2;   // Reserved
  localparam logic [2:0] SRC_D32    = 3'h3;   // Main clock / 32
  localparam logic [2:0] SRC_D64    = 3'h4;   // Main clock / 64
  localparam logic [2:0] SRC_D128   = 3'h5;   // Main clock / 128
  localparam logic [2:0] SRC_RSV_B  = 3'h7;   // Reserved
  // Reference ticks per common slice (base frame / 8)
  localparam int         REF_HZ     = 32768;  // Reference clock rate
  localparam int         BASE_00_HZ = 256;    // Frame rate code 00
  localparam int         BASE_01_HZ = 128;    // Frame rate code 01
  localparam int         BASE_10_HZ = 170;    // Frame rate code 10
  localparam int         BASE_11_HZ = 512;    // Frame rate code 11
  localparam int         SLICES     = 8;      // Slices in a base frame
  localparam logic [5:0] SL_00 = 6'(REF_HZ / (BASE_00_HZ * SLICES));
  localparam logic [5:0] SL_01 = 6'(REF_HZ / (BASE_01_HZ * SLICES));
  localparam logic [5:0] SL_10 = 6'(REF_HZ / (BASE_10_HZ * SLICES));
  localparam logic [5:0] SL_11 = 6'(REF_HZ / (BASE_11_HZ * SLICES));
  // Common counts per ratio
  localparam logic [4:0] NCOM_8     = 5'h08;  // 1/8
  localparam logic [4:0] NCOM_11    = 5'h0B;  // 1/11
  localparam logic [4:0] NCOM_16    = 5'h10;  // 1/16

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       sixteen;     // ratio_sixteen_select
    logic       eleven;      // ratio_eleven_select
    logic [2:0] clk_src;     // clock_source_select
    logic       rsvd;        // Reserved
    logic [1:0] frame_rate;  // frame_rate_select
  } sdc_ctrl_t;

  // Processor data-space access
  typedef struct packed {
    logic       wr;          // Write strobe
    logic       rd;          // Read strobe
    logic       page;        // Display RAM page (0 = page 1)
    logic [7:0] addr;        // Data-space address
    logic [7:0] wdata;       // Write data
  } sdc_bus_t;
endpackage

//--- sdc_scan.sv
// Segment display scan controller: control register, two-page display RAM,
// reference divider, common scan and segment drive.
// Assumes the processor bus is on mclk; slow oscillator, stop and fail are async.
//
// How it works
// - Ratio bits choose 1/8, 1/11, 1/16
// - Frame code picks 128/170/256/512 Hz base
// - Divisors follow the frequency figures, not table
// - Wider ratios stretch the frame proportionally
// - Two 64-byte RAM pages at 00h-3Fh
// - RAM bit one drives its dot on
// - 1/8 scans 56x8 from page 1
// - 1/16 scans 48x16, skips bytes 00-07
// - 1/11 scans 48x11, ignores page-2 bits 3-7
// - Bytes 38h-3Fh never displayed
// - Reset clears control, display off
// - Stop on main clock grounds all lines
// - Clock source decode, 000 blanks
// - Source change applies at frame end
// - Control register bit layout
// - Main clock divided by 32-256
// - Oscillator failure grounds all lines
`timescale 1ns/1ps
`default_nettype none
module sdc_scan (
  input  wire logic             mclk,        // System clock, 100 MHz
  input  wire logic             rst_n,       // Async reset, active low
  input  wire sdc_pkg::sdc_bus_t bus,        // Processor data-space access
  input  wire logic             slow_osc,    // Auxiliary slow oscillator
  input  wire logic             stop_mode,   // Stop instruction in force
  input  wire logic             osc_fail,    // Selected oscillator failed
  output logic [7:0]            rdata,       // Read data
  output logic [55:0]           seg_out,     // Segment lines, 1 = dot on
  output logic [15:0]           com_out,     // common_plate_lines, one-hot
  output logic                  lines_on     // Low = every line grounded
);
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Control value has a legal ratio and a running clock source
  function automatic logic cfg_ok(input sdc_pkg::sdc_ctrl_t c);
    cfg_ok = !(c.sixteen && c.eleven) && c.clk_src != sdc_pkg::SRC_OFF &&
             c.clk_src != sdc_pkg::SRC_RSV_A && c.clk_src != sdc_pkg::SRC_RSV_B;
  endfunction
  // Number of commons scanned
  function automatic logic [4:0] ncom(input sdc_pkg::sdc_ctrl_t c);
    ncom = c.sixteen ? sdc_pkg::NCOM_16 : c.eleven ? sdc_pkg::NCOM_11 : sdc_pkg::NCOM_8;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] aux_r, aux_nxt;       // Slow oscillator sync plus edge stage
  logic [1:0] stp_r, stp_nxt;       // Stop sync
  logic [1:0] fl_r,  fl_nxt;        // Failure sync
  always_comb begin
    aux_nxt = {aux_r[1:0], slow_osc};
    stp_nxt = {stp_r[0], stop_mode};
    fl_nxt  = {fl_r[0], osc_fail};
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_r <= 3'h0;
      stp_r <= 2'h0;
      fl_r  <= 2'h0;
    end else begin
      aux_r <= aux_nxt;
      stp_r <= stp_nxt;
      fl_r  <= fl_nxt;
    end
  end
  logic stop_s, fail_s, aux_rise;   // Synchronised levels and slow edge
  assign stop_s   = stp_r[1];
  assign fail_s   = fl_r[1];
  assign aux_rise = aux_r[1] && !aux_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Control register and display RAM
  sdc_pkg::sdc_ctrl_t ctrl_r, ctrl_nxt;          // Software view
  logic [7:0] ram_r   [2][sdc_pkg::RAM_BYTES];   // Display RAM, no reset
  logic [7:0] ram_nxt [2][sdc_pkg::RAM_BYTES];
  logic [7:0] rdata_nxt;                         // Read data next
  logic       ctrl_hit, ram_hit;                 // Address decode
  always_comb begin
    ctrl_hit  = bus.addr == sdc_pkg::CTRL_ADDR;
    ram_hit   = bus.addr <= sdc_pkg::RAM_LAST;
    ctrl_nxt  = ctrl_r;
    ram_nxt   = ram_r;
    rdata_nxt = 8'h00;
    if (bus.wr && ctrl_hit) begin
      ctrl_nxt = bus.wdata;
    end else if (bus.wr && ram_hit) begin
      ram_nxt[bus.page][bus.addr[5:0]] = bus.wdata;
    end
    if (bus.rd && ctrl_hit) begin
      rdata_nxt = ctrl_r;
    end else if (bus.rd && ram_hit) begin
      rdata_nxt = ram_r[bus.page][bus.addr[5:0]];
    end
  end
  // Control resets to all zero, display off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= sdc_pkg::CTRL_RESET;
      rdata  <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata  <= rdata_nxt;
    end
  end
  // RAM contents are undefined after reset
  always_ff @(posedge mclk) begin
    ram_r <= ram_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Active configuration, reference tick and scan counters
  sdc_pkg::sdc_ctrl_t act_r, act_nxt;  // Configuration in use
  logic [7:0] div_r, div_nxt;          // Main clock divider
  logic [5:0] sl_r, sl_nxt;            // Ticks within slice
  logic [3:0] ci_r, ci_nxt;            // Active common index
  logic       main_src, halted, ref_tick, slice_end, frame_end, blank;
  logic [7:0] div_last;                // Main divider terminal count
  logic [5:0] sl_last;                 // Slice terminal count
  always_comb begin
    main_src = act_r.clk_src >= sdc_pkg::SRC_D32;
    halted   = stop_s && main_src;
    case (act_r.clk_src)
      sdc_pkg::SRC_D32:  div_last = 8'h1F;
      sdc_pkg::SRC_D64:  div_last = 8'h3F;
      sdc_pkg::SRC_D128: div_last = 8'h7F;
      default:           div_last = 8'hFF;
    endcase
    case (act_r.frame_rate)
      2'h0:    sl_last = sdc_pkg::SL_00 - 6'h01;
      2'h1:    sl_last = sdc_pkg::SL_01 - 6'h01;
      2'h2:    sl_last = sdc_pkg::SL_10 - 6'h01;
      default: sl_last = sdc_pkg::SL_11 - 6'h01;
    endcase
    // No main clock in stop, so the divider clears to zero
    // A switch to a shorter divider must not run the count past its end
    div_nxt  = (halted || !main_src || div_r >= div_last) ? 8'h00 : div_r + 8'h01;
    ref_tick = cfg_ok(act_r) && !halted &&
               (main_src ? div_r == div_last : aux_rise);
    slice_end = ref_tick && sl_r == sl_last;
    frame_end = slice_end && {1'b0, ci_r} == ncom(act_r) - 5'h01;
    sl_nxt = slice_end ? 6'h00 : ref_tick ? sl_r + 6'h01 : sl_r;
    ci_nxt = frame_end ? 4'h0 : slice_end ? ci_r + 4'h1 : ci_r;
    // Change takes effect only when a frame closes or nothing runs
    act_nxt = (frame_end || !cfg_ok(act_r)) ? ctrl_r : act_r;
    if (!cfg_ok(act_r)) begin
      sl_nxt = 6'h00;
      ci_nxt = 4'h0;
    end
    blank = !cfg_ok(act_r) || halted || fail_s || act_r.rsvd;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= sdc_pkg::CTRL_RESET;
      div_r <= 8'h00;
      sl_r  <= 6'h00;
      ci_r  <= 4'h0;
    end else begin
      act_r <= act_nxt;
      div_r <= div_nxt;
      sl_r  <= sl_nxt;
      ci_r  <= ci_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Segment and common drive
  logic [55:0] seg_nxt;   // Segment levels next
  logic [15:0] com_nxt;   // Common levels next
  logic [5:0]  byte_i;    // RAM byte for a wide segment
  always_comb begin
    seg_nxt = '0;
    com_nxt = '0;
    byte_i  = '0;
    if (!blank) begin
      com_nxt = 16'h0001 << ci_r;
      for (int s = 0; s < sdc_pkg::SEG_MAX; s++) begin
        byte_i = 6'(s + sdc_pkg::BYTE_SKIP);
        if (!act_r.sixteen && !act_r.eleven) begin
          seg_nxt[s] = ram_r[0][s][ci_r[2:0]];
        end else if (s < sdc_pkg::SEG_WIDE) begin
          // Bytes 08h..37h; page 2 from common 8 on
          seg_nxt[s] = ram_r[ci_r[3]][byte_i][ci_r[2:0]];
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seg_out  <= '0;
      com_out  <= '0;
      lines_on <= 1'b0;
    end else begin
      seg_out  <= seg_nxt;
      com_out  <= com_nxt;
      lines_on <= !blank;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_ctrl_write: assert property (bus.wr && bus.addr == sdc_pkg::CTRL_ADDR |=>
    ctrl_r == $past(bus.wdata)) else $error("control write lost");
  a_ctrl_read: assert property (bus.rd && bus.addr == sdc_pkg::CTRL_ADDR && !bus.wr |=>
    rdata == $past(ctrl_r)) else $error("control read wrong");
  a_stop_ground: assert property (stop_s && main_src |=> !lines_on && com_out == 16'h0000)
    else $error("lines driven in stop");
  a_fail_ground: assert property (fail_s |=> !lines_on && seg_out == '0)
    else $error("lines driven on failure");
  a_rsvd_blank: assert property (act_r.sixteen && act_r.eleven |=> !lines_on)
    else $error("reserved ratio shown");
  a_src_off: assert property (act_r.clk_src == sdc_pkg::SRC_OFF |=> !lines_on)
    else $error("display on with clock off");
  a_com_onehot: assert property (lines_on |-> $onehot(com_out))
    else $error("common drive not one-hot");
  a_com_range8: assert property (lines_on && !act_r.sixteen && !act_r.eleven ##1
    $stable(act_r) |-> com_out[15:8] == 8'h00) else $error("1/8 drives high commons");
  a_wide_seg: assert property (lines_on && (act_r.sixteen || act_r.eleven) ##1
    $stable(act_r) |-> seg_out[55:48] == 8'h00) else $error("unused segments driven");
  a_cfg_frame: assert property ($changed(act_r) |-> $past(frame_end || !cfg_ok(act_r)))
    else $error("config changed mid frame");
  a_d32_tick: assert property (act_r.clk_src == sdc_pkg::SRC_D32 && !halted &&
    div_r == 8'h1F |=> div_r == 8'h00) else $error("divide by 32 wrong");
  a_d32_range: assert property (act_r.clk_src == sdc_pkg::SRC_D32 && !halted &&
    div_r <= 8'h1F |=> div_r <= 8'h1F) else $error("divide by 32 overruns");

  c_frame8:  cover property (frame_end && ncom(act_r) == sdc_pkg::NCOM_8);
  c_frame11: cover property (frame_end && ncom(act_r) == sdc_pkg::NCOM_11);
  c_frame16: cover property (frame_end && ncom(act_r) == sdc_pkg::NCOM_16);
  c_stop_aux: cover property (stop_s && act_r.clk_src == sdc_pkg::SRC_AUX && lines_on);
endmodule
`default_nettype wire

//--- sdc_panel.sv
// Panel model: far side of the segment display scan controller.
// Assumes it only watches the driven lines on mclk; it drives nothing back.
`timescale 1ns/1ps
`default_nettype none
module sdc_panel (
  input  wire logic        mclk,        // System clock
  input  wire logic [55:0] seg_out,     // Segment lines
  input  wire logic [15:0] com_out,     // Common plate lines
  input  wire logic        lines_on,    // Low = all lines grounded
  output logic [55:0]      rows [16],   // Last row seen per common
  output logic [7:0]       faults       // Illegal line states seen
);
  ////////////////////////////////////////////////////////////////////
  // Latch the row shown under each common, flag unsafe drive
  initial faults = 8'h00;
  always @(posedge mclk) begin
    if (lines_on && $countones(com_out) == 1) begin
      for (int c = 0; c < 16; c++) begin
        if (com_out[c]) rows[c] <= seg_out;
      end
    end
    if ($countones(com_out) > 1) faults <= faults + 8'h01;
    if (!lines_on && com_out !== 16'h0000) faults <= faults + 8'h01;
  end
endmodule
`default_nettype wire

//--- segment_display_scan_control_tb_top.sv
// Testbench for the segment display scan controller.
// Assumes sdc_pkg and the panel model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module segment_display_scan_control_tb_top;
  logic              mclk = 1'b0;        // 100 MHz clock
  logic              rst_n = 1'b0;       // Reset, active low
  sdc_pkg::sdc_bus_t bus = '0;           // Processor access
  logic              slow_osc = 1'b0;    // Fast stand-in for slow oscillator
  logic              stop_mode = 1'b0;   // Stop in force
  logic              osc_fail = 1'b0;    // Oscillator failure
  logic [7:0]        rdata;              // Read data
  logic [55:0]       seg_out;            // Segment lines
  logic [15:0]       com_out;            // Common lines
  logic              lines_on;           // Lines driven
  logic [55:0]       rows [16];          // Rows captured by panel
  logic [7:0]        faults;             // Panel fault count
  logic [7:0]        ram [2][64];        // Expected RAM image
  logic [7:0]        exp_q [$];          // Expected read data
  logic [55:0]       row_exp;            // Expected row
  logic              rd_d = 1'b0;        // Read issued last edge
  int                mismatches = 0;     // Mismatch count
  int                samples_checked = 0; // Comparison count
  logic [7:0]        v;                  // Random value

  always #5 mclk = ~mclk;
  always #100 slow_osc = ~slow_osc;

  sdc_scan sdc_scan_i (.mclk(mclk), .rst_n(rst_n), .bus(bus), .slow_osc(slow_osc),
    .stop_mode(stop_mode), .osc_fail(osc_fail), .rdata(rdata), .seg_out(seg_out),
    .com_out(com_out), .lines_on(lines_on));
  sdc_panel sdc_panel_i (.mclk(mclk), .seg_out(seg_out), .com_out(com_out),
    .lines_on(lines_on), .rows(rows), .faults(faults));

  ////////////////////////////////////////////////////////////////////
  // Watcher: read data lands one edge after the read strobe
  always @(posedge mclk) begin
    if (rd_d) begin
      `CHK("rdata", exp_q.pop_front(), rdata)
    end
    rd_d <= bus.rd;
  end

  ////////////////////////////////////////////////////////////////////
  // One-cycle bus access, launched at the falling edge
  task automatic bus_op(input logic wr, input logic pg, input logic [7:0] a,
                        input logic [7:0] d, input logic [7:0] e);
    @(negedge mclk);
    bus = '{wr: wr, rd: ~wr, page: pg, addr: a, wdata: d};
    if (!wr) exp_q.push_back(e);
    @(negedge mclk);
    bus = '0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run length
  initial begin
    #600000;
    mismatches++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h57303f84));
    wait_cyc(6);
    rst_n = 1'b1;
    `CHK("lines_on", 1'b0, lines_on)
    bus_op(1'b0, 1'b0, sdc_pkg::CTRL_ADDR, 8'h00, sdc_pkg::CTRL_RESET);
    // Control bit layout, reserved bit stored too
    repeat (4) begin
      // Source field kept at off so the random value never starts a long frame
      v = 8'($urandom) & 8'hC7;
      bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, v, 8'h00);
      bus_op(1'b0, 1'b0, sdc_pkg::CTRL_ADDR, 8'h00, v);
    end
    bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, 8'h03, 8'h00);
    bus_op(1'b0, 1'b0, 8'h80, 8'h00, 8'h00);
    // Fill both pages with random dots
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 64; a++) begin
        ram[p][a] = 8'($urandom);
        bus_op(1'b1, p[0], a[7:0], ram[p][a], 8'h00);
      end
    end
    // 1/8 from main clock / 32, rate 11: slice 256 cycles
    bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, 8'h1B, 8'h00);
    wait_cyc(5000);
    `CHK("lines_on", 1'b1, lines_on)
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 56; s++) row_exp[s] = ram[0][s][c];
      `CHK("row8", row_exp, rows[c])
    end
    // 1/16: both pages, bytes 00-07 and 38h-3Fh unseen
    bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, 8'h9B, 8'h00);
    wait_cyc(12000);
    for (int c = 0; c < 16; c++) begin
      for (int s = 0; s < 48; s++) row_exp[s] = ram[c / 8][s + 8][c % 8];
      `CHK("row16", row_exp[47:0], rows[c][47:0])
    end
    // Stop and failure on the main source ground every line
    stop_mode = 1'b1;
    wait_cyc(10);
    `CHK("stop", 1'b0, lines_on)
    stop_mode = 1'b0;
    osc_fail = 1'b1;
    wait_cyc(10);
    `CHK("fail", 1'b0, lines_on)
    osc_fail = 1'b0;
    // Reserved ratio keeps the panel blank after frame end
    bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, 8'hDB, 8'h00);
    wait_cyc(5000);
    `CHK("rsvd", 1'b0, lines_on)
    bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, 8'h03, 8'h00);
    wait_cyc(20);
    `CHK("off", 1'b0, lines_on)
    // Auxiliary source keeps running through stop
    bus_op(1'b1, 1'b0, sdc_pkg::CTRL_ADDR, 8'h0B, 8'h00);
    wait_cyc(400);
    stop_mode = 1'b1;
    wait_cyc(400);
    `CHK("aux", 1'b1, lines_on)
    stop_mode = 1'b0;
    `CHK("faults", 8'h00, faults)
    wait_cyc(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
